// *** src/pcs_pkg.sv ***
// Purpose: shared constants for the peripheral clock select and oscillator control block
// Assumes: registers sit at fixed 32-bit byte addresses on the plain register port
// Notes:   field positions, reset values and codes live here only
package pcs_pkg;

	// ==========================================================
	// register addresses
	localparam logic [31:0] PCS_SYS_ADDR = 32'h400f_4000;
	localparam logic [31:0] PCS_OSC_ADDR = 32'h400f_4004;

	// ==========================================================
	// system clock control fields
	localparam int PCS_PRESC_LSB = 8;
	localparam int PCS_SRC0_BIT  = 12;
	localparam int PCS_LOWF_BIT  = 13;
	localparam int PCS_COSEL_LSB = 16;
	localparam int PCS_ADC_BIT   = 20;
	localparam int PCS_USB_BIT   = 23;

	localparam logic [2:0] PCS_PRESC_RST = 3'h0;
	localparam logic [1:0] PCS_COSEL_RST = 2'h1;

	// ==========================================================
	// oscillation control fields
	localparam int PCS_WSTART_BIT = 0;
	localparam int PCS_WSTAT_BIT  = 1;
	localparam int PCS_PLL_BIT    = 2;
	localparam int PCS_WSRC_BIT   = 3;
	localparam int PCS_FIX_LSB    = 4;

	localparam logic [3:0] PCS_FIX_RST = 4'h3;

	// ==========================================================
	// codes
	localparam logic [2:0] PCS_PRESC_MAX  = 3'h5;
	localparam logic [1:0] PCS_COSEL_LOWF = 2'h0;
	localparam logic [1:0] PCS_COSEL_HALF = 2'h1;
	localparam logic [1:0] PCS_COSEL_SYS  = 2'h2;
	localparam logic [1:0] PCS_COSEL_TMR  = 2'h3;

	// warm-up ticks of the selected oscillator
	localparam logic [15:0] PCS_WARMUP_TICKS = 16'h0100;

	typedef enum logic [0:0] {
		PCS_WU_IDLE,
		PCS_WU_RUN
	} pcs_wu_e;

endpackage : pcs_pkg

// *** src/pcs_presc_if.sv ***
// Purpose: carries the source pulse and divide code to the prescaler and the divided pulse back from it
// Assumes: all signals on core_clk
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface pcs_presc_if;
	logic       src_en;
	logic [2:0] code;
	logic       div_en;

	modport ctrl (output src_en, output code, input div_en);
	modport div  (input src_en, input code, output div_en);
endinterface : pcs_presc_if
`default_nettype wire

// *** src/pcs_prescaler.sv ***
// Purpose: divides a clock enable pulse stream by a power of two
// Assumes: src_en is a one-cycle pulse on core_clk
// Notes:   reserved codes produce no pulses
`timescale 1ns/1ps
`default_nettype none
module pcs_prescaler
	import pcs_pkg::*;
(
	input  wire logic core_clk, // core clock
	input  wire logic rstn,     // async reset, active low
	pcs_presc_if.div  pif       // source, code, divided pulse
);
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [4:0] mask;

	// ==========================================================
	// divider
	always_comb begin
		mask   = 5'((6'h01 << pif.code) - 6'h01);
		cnt_d  = pif.src_en ? 5'(cnt_q + 5'h01) : cnt_q;
		// codes 0..5 divide by 1..32, others stop
		pif.div_en = pif.src_en && (pif.code <= PCS_PRESC_MAX)
		             && ((cnt_q & mask) == mask);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ==========================================================
	// checks
	AST_PRESC_RSVD: assert property (@(posedge core_clk) disable iff (!rstn)
		(pif.code > PCS_PRESC_MAX) |-> !pif.div_en)
		else $error("prescaler pulsed on reserved code");

	// outcome and code of the previous source pulse, for the alternation check
	logic last_div_q, last_div_d;
	logic last_one_q, last_one_d;

	always_comb begin
		last_div_d = pif.src_en ? pif.div_en : last_div_q;
		last_one_d = pif.src_en ? (pif.code == 3'h1) : last_one_q;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			last_div_q <= 1'b0;
			last_one_q <= 1'b0;
		end else begin
			last_div_q <= last_div_d;
			last_one_q <= last_one_d;
		end
	end

	AST_PRESC_DIV2: assert property (@(posedge core_clk) disable iff (!rstn)
		(pif.src_en && pif.code == 3'h1 && last_one_q) |-> (pif.div_en != last_div_q))
		else $error("divide by two did not alternate");

	AST_PRESC_DIV1: assert property (@(posedge core_clk) disable iff (!rstn)
		(pif.code == 3'h0) |-> (pif.div_en == pif.src_en))
		else $error("divide by one does not follow source");

endmodule : pcs_prescaler
`default_nettype wire

// *** src/pcs_clock_ctrl.sv ***
// Purpose: peripheral clock select, prescaler, clock output, gates and warm-up control
// Assumes: all clocks arrive as one-cycle enable pulses on core_clk
// Notes:   read data stand one cycle after the read strobe
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_ctrl
	import pcs_pkg::*;
#(
	parameter logic [15:0] WARMUP_TICKS = PCS_WARMUP_TICKS
) (
	input  wire logic        core_clk,          // core clock, 100 MHz
	input  wire logic        rstn,              // async reset, active low
	input  wire logic [31:0] reg_addr,          // register byte address
	input  wire logic [31:0] reg_wdata,         // write data
	input  wire logic        reg_wr,            // write strobe
	input  wire logic        reg_rd,            // read strobe
	output logic      [31:0] reg_rdata,         // read data, cycle after strobe
	input  wire logic        gear_clk_en,       // geared clock pulse
	input  wire logic        fc_clk_en,         // undivided high-speed clock pulse
	input  wire logic        fs_clk_en,         // low-frequency clock pulse
	input  wire logic        fsys_clk_en,       // system clock pulse
	input  wire logic        tmr_clk_en,        // timer prescale clock pulse
	input  wire logic        main_osc_en,       // main oscillator tick
	input  wire logic        lows_osc_en,       // low-speed oscillator tick
	output logic             periph_clk_en,     // peripheral source pulse
	output logic             presc_clk_en,      // prescaled peripheral pulse
	output logic             clock_output_pin,  // clock output pin level
	output logic             adc_clk_supply,    // converter clock running
	output logic             usb_host_rst,      // usb host held in reset
	output logic             pll_enable,        // pll running
	output logic             warmup_source_select, // 1 low-speed oscillator
	output logic             warmup_status      // warm-up in progress
);
	// ==========================================================
	// register file
	logic [2:0] presc_q,  presc_d;
	logic       src0_q,   src0_d;
	logic       lowf_q,   lowf_d;
	logic [1:0] cosel_q,  cosel_d;
	logic       adc_q,    adc_d;
	logic       usb_q,    usb_d;
	logic       pll_q,    pll_d;
	logic       wsrc_q,   wsrc_d;
	logic [3:0] fix_q,    fix_d;
	logic [31:0] rdata_q, rdata_d;
	logic        sys_wr, osc_wr, wu_start;
	logic [31:0] sys_view, osc_view;

	always_comb begin
		sys_wr = reg_wr && (reg_addr == PCS_SYS_ADDR);
		osc_wr = reg_wr && (reg_addr == PCS_OSC_ADDR);
		presc_d = presc_q;
		src0_d  = src0_q;
		lowf_d  = lowf_q;
		cosel_d = cosel_q;
		adc_d   = adc_q;
		usb_d   = usb_q;
		pll_d   = pll_q;
		wsrc_d  = wsrc_q;
		fix_d   = fix_q;
		if (sys_wr) begin
			presc_d = reg_wdata[PCS_PRESC_LSB +: 3];
			src0_d  = reg_wdata[PCS_SRC0_BIT];
			lowf_d  = reg_wdata[PCS_LOWF_BIT];
			cosel_d = reg_wdata[PCS_COSEL_LSB +: 2];
			adc_d   = reg_wdata[PCS_ADC_BIT];
			usb_d   = reg_wdata[PCS_USB_BIT];
		end
		if (osc_wr) begin
			pll_d  = reg_wdata[PCS_PLL_BIT];
			wsrc_d = reg_wdata[PCS_WSRC_BIT];
			fix_d  = reg_wdata[PCS_FIX_LSB +: 4];
		end
		wu_start = osc_wr && reg_wdata[PCS_WSTART_BIT];
		// only held fields and the warm-up status appear, all else reads zero
		sys_view = 32'h0000_0000;
		sys_view[PCS_PRESC_LSB +: 3] = presc_q;
		sys_view[PCS_SRC0_BIT]       = src0_q;
		sys_view[PCS_LOWF_BIT]       = lowf_q;
		sys_view[PCS_COSEL_LSB +: 2] = cosel_q;
		sys_view[PCS_ADC_BIT]        = adc_q;
		sys_view[PCS_USB_BIT]        = usb_q;
		osc_view = 32'h0000_0000;
		osc_view[PCS_WSTAT_BIT]      = warmup_status;
		osc_view[PCS_PLL_BIT]        = pll_q;
		osc_view[PCS_WSRC_BIT]       = wsrc_q;
		osc_view[PCS_FIX_LSB +: 4]   = fix_q;
		rdata_d = 32'h0000_0000;
		if (reg_rd && reg_addr == PCS_SYS_ADDR) begin
			rdata_d = sys_view;
		end else if (reg_rd && reg_addr == PCS_OSC_ADDR) begin
			rdata_d = osc_view;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			presc_q <= PCS_PRESC_RST;
			src0_q  <= 1'b0;
			lowf_q  <= 1'b0;
			cosel_q <= PCS_COSEL_RST;
			adc_q   <= 1'b0;
			usb_q   <= 1'b0;
			pll_q   <= 1'b0;
			wsrc_q  <= 1'b0;
			fix_q   <= PCS_FIX_RST;
			rdata_q <= 32'h0000_0000;
		end else begin
			presc_q <= presc_d;
			src0_q  <= src0_d;
			lowf_q  <= lowf_d;
			cosel_q <= cosel_d;
			adc_q   <= adc_d;
			usb_q   <= usb_d;
			pll_q   <= pll_d;
			wsrc_q  <= wsrc_d;
			fix_q   <= fix_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata            = rdata_q;
	assign adc_clk_supply       = !adc_q;
	assign usb_host_rst         = usb_q;
	assign pll_enable           = pll_q;
	assign warmup_source_select = wsrc_q;

	// ==========================================================
	// peripheral source and prescaler
	pcs_presc_if pif ();
	logic src_en;
	logic per_q, per_d, pre_q, pre_d;

	always_comb begin
		if (lowf_q) begin
			src_en = fs_clk_en;
		end else if (src0_q) begin
			src_en = fc_clk_en;
		end else begin
			src_en = gear_clk_en;
		end
		pif.src_en = src_en;
		pif.code   = presc_q;
		per_d      = src_en;
		pre_d      = pif.div_en;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			per_q <= 1'b0;
			pre_q <= 1'b0;
		end else begin
			per_q <= per_d;
			pre_q <= pre_d;
		end
	end

	pcs_prescaler u_presc (
		.core_clk (core_clk),
		.rstn     (rstn),
		.pif      (pif.div)
	);

	assign periph_clk_en = per_q;
	assign presc_clk_en  = pre_q;

	// ==========================================================
	// clock output: pin toggles on each pulse of the chosen rate
	logic half_q, half_d, pin_q, pin_d, out_en;

	always_comb begin
		half_d = fsys_clk_en ? !half_q : half_q;
		case (cosel_q)
			PCS_COSEL_LOWF: out_en = fs_clk_en;
			PCS_COSEL_HALF: out_en = fsys_clk_en && half_q;
			PCS_COSEL_SYS:  out_en = fsys_clk_en;
			PCS_COSEL_TMR:  out_en = tmr_clk_en;
			default:        out_en = 1'b0;
		endcase
		pin_d = out_en ? !pin_q : pin_q;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			half_q <= 1'b0;
			pin_q  <= 1'b0;
		end else begin
			half_q <= half_d;
			pin_q  <= pin_d;
		end
	end

	assign clock_output_pin = pin_q;

	// ==========================================================
	// warm-up timer
	pcs_wu_e     wu_q, wu_d;
	logic [15:0] wcnt_q, wcnt_d;
	logic        tick;

	always_comb begin
		tick   = wsrc_q ? lows_osc_en : main_osc_en;
		wu_d   = wu_q;
		wcnt_d = wcnt_q;
		case (wu_q)
			PCS_WU_IDLE: begin
				if (wu_start) begin
					wu_d   = PCS_WU_RUN;
					wcnt_d = WARMUP_TICKS;
				end
			end
			PCS_WU_RUN: begin
				if (wu_start) begin
					wcnt_d = WARMUP_TICKS;
				end else if (tick) begin
					wcnt_d = 16'(wcnt_q - 16'h0001);
					if (wcnt_q <= 16'h0001) begin
						wu_d = PCS_WU_IDLE;
					end
				end
			end
			default: wu_d = PCS_WU_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wu_q   <= PCS_WU_IDLE;
			wcnt_q <= 16'h0000;
		end else begin
			wu_q   <= wu_d;
			wcnt_q <= wcnt_d;
		end
	end

	assign warmup_status = (wu_q == PCS_WU_RUN);

	// ==========================================================
	// checks
	sequence s_sys_wr;
		reg_wr && reg_addr == PCS_SYS_ADDR;
	endsequence

	sequence s_osc_wr;
		reg_wr && reg_addr == PCS_OSC_ADDR;
	endsequence

	AST_SRC_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
		(!lowf_q && !src0_q) |=> (periph_clk_en == $past(gear_clk_en)))
		else $error("geared clock not selected");

	AST_LOWF_SRC: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_sys_wr ##0 reg_wdata[PCS_LOWF_BIT]) ##1 1'b1 |=> (periph_clk_en == $past(fs_clk_en)))
		else $error("low-frequency clock not selected");

	AST_FC_FIXED: assert property (@(posedge core_clk) disable iff (!rstn)
		(!lowf_q && src0_q && !fc_clk_en) |=> !periph_clk_en)
		else $error("peripheral pulse without undivided clock pulse");

	AST_CLKOUT_SYS: assert property (@(posedge core_clk) disable iff (!rstn)
		(cosel_q == PCS_COSEL_SYS && fsys_clk_en) |=> $changed(clock_output_pin))
		else $error("clock output did not follow system clock");

	AST_ADC_STOP: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_sys_wr ##0 reg_wdata[PCS_ADC_BIT]) |=> !adc_clk_supply)
		else $error("converter clock not stopped");

	AST_USB_RST: assert property (@(posedge core_clk) disable iff (!rstn)
		s_sys_wr |=> (usb_host_rst == $past(reg_wdata[PCS_USB_BIT])))
		else $error("usb host reset does not follow write");

	AST_PLL_EN: assert property (@(posedge core_clk) disable iff (!rstn)
		s_osc_wr |=> (pll_enable == $past(reg_wdata[PCS_PLL_BIT])))
		else $error("pll enable does not follow write");

	AST_WU_START: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_osc_wr ##0 reg_wdata[PCS_WSTART_BIT]) |=> warmup_status [*2])
		else $error("warm-up did not start");

	AST_WU_NOSTART: assert property (@(posedge core_clk) disable iff (!rstn)
		(!warmup_status && !wu_start) |=> !warmup_status)
		else $error("warm-up started without a start write");

	AST_WU_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
		(warmup_status && !tick && !wu_start) |=> $stable(wcnt_q) && warmup_status)
		else $error("warm-up counted without selected oscillator tick");

	AST_WU_DONE: assert property (@(posedge core_clk) disable iff (!rstn)
		$fell(warmup_status) |-> ($past(wcnt_q) == 16'h0001 && $past(tick)))
		else $error("warm-up ended early");

	AST_RSVD_READ: assert property (@(posedge core_clk) disable iff (!rstn)
		(reg_rd && reg_addr == PCS_SYS_ADDR) |=> (reg_rdata[31:24] == 8'h00
		&& reg_rdata[22:21] == 2'h0 && reg_rdata[19:18] == 2'h0 && reg_rdata[15:14] == 2'h0
		&& reg_rdata[11] == 1'b0 && reg_rdata[7:0] == 8'h00))
		else $error("unused system control bits read nonzero");

endmodule : pcs_clock_ctrl
`default_nettype wire

// *** verif/pcs_clock_ctrl_bench.sv ***
// Purpose: self-checking bench for pcs_clock_ctrl
// Assumes: WARMUP_TICKS shortened to 4, registers reached over the plain port
// Notes:   register model kept in bench variables, pulse counts compared per run
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_ctrl_bench;
	import pcs_pkg::*;

	// ==========================================================
	// signals and model state
	localparam int          WT = 4;
	localparam int          CS[4] = '{2, 3, 3, 4};
	localparam logic [31:0] CW[4] = '{32'h0000_2000, 32'h0001_1000, 32'h0002_0000, 32'h0003_2000};
	logic        core_clk;
	logic        rstn;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [4:0]  src;      // gear, fc, fs, fsys, tmr
	logic [1:0]  osc;      // main, low-speed
	logic        periph_clk_en;
	logic        presc_clk_en;
	logic        clock_output_pin;
	logic        adc_clk_supply;
	logic        usb_host_rst;
	logic        pll_enable;
	logic        warmup_source_select;
	logic        warmup_status;
	integer      seed = 62327;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          presc_cnt;
	int          tog_cnt;
	logic [31:0] sys_m;
	logic [31:0] osc_m;
	logic [31:0] v;
	logic        mon_on = 1'b0;
	logic        sel_prev = 1'b0;
	logic        pin_prev = 1'b0;

	pcs_clock_ctrl #(.WARMUP_TICKS(16'h0004)) u_pcs_clock_ctrl (
		.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gear_clk_en(src[0]), .fc_clk_en(src[1]), .fs_clk_en(src[2]),
		.fsys_clk_en(src[3]), .tmr_clk_en(src[4]),
		.main_osc_en(osc[0]), .lows_osc_en(osc[1]),
		.periph_clk_en(periph_clk_en), .presc_clk_en(presc_clk_en),
		.clock_output_pin(clock_output_pin), .adc_clk_supply(adc_clk_supply),
		.usb_host_rst(usb_host_rst), .pll_enable(pll_enable),
		.warmup_source_select(warmup_source_select), .warmup_status(warmup_status)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ==========================================================
	// compare and report
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmp_bit(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask : cmp_bit

	task automatic final_report();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	// ==========================================================
	// register port and stimulus
	function automatic int psel();
		return sys_m[PCS_LOWF_BIT] ? 2 : (sys_m[PCS_SRC0_BIT] ? 1 : 0);
	endfunction : psel

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a == PCS_SYS_ADDR)
			sys_m = d & 32'h0093_3700;
		if (a == PCS_OSC_ADDR)
			osc_m = d & 32'h0000_00fc;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, e);
		@(posedge core_clk);
		#1 cmp(reg_rdata, 32'h0);
	endtask : rd

	task automatic chk_outs();
		cmp(32'({adc_clk_supply, usb_host_rst, pll_enable, warmup_source_select}),
			32'({~sys_m[PCS_ADC_BIT], sys_m[PCS_USB_BIT], osc_m[PCS_PLL_BIT],
			osc_m[PCS_WSRC_BIT]}));
	endtask : chk_outs

	// random pulses on all sources until n pulses of source k were sent
	task automatic pulses(input int k, input int n);
		int c;
		c         = 0;
		presc_cnt = 0;
		tog_cnt   = 0;
		mon_on <= 1'b1;
		while (c < n) begin
			@(posedge core_clk);
			v = $random(seed);
			src <= v[4:0];
			osc <= v[6:5];
			if (v[k])
				c++;
		end
		@(posedge core_clk);
		src <= 5'h0;
		osc <= 2'h0;
		repeat (3) @(posedge core_clk);
		mon_on <= 1'b0;
		@(posedge core_clk);
	endtask : pulses

	// alternate a tick of the other oscillator with one of oscillator s
	task automatic ticks(input int s, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			osc <= 2'(1 << (1 - s));
			@(posedge core_clk);
			osc <= 2'(1 << s);
		end
		@(posedge core_clk);
		osc <= 2'h0;
	endtask : ticks

	// ==========================================================
	// per-cycle monitor and timeout
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			miscompares++;
			final_report();
		end
		if (mon_on) begin
			cmp_bit(periph_clk_en, sel_prev);
			presc_cnt += int'(presc_clk_en);
			tog_cnt += int'(clock_output_pin != pin_prev);
		end
		sel_prev = src[psel()];
		pin_prev = clock_output_pin;
	end

	// ==========================================================
	// main sequence
	initial begin
		rstn      = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 32'h0;
		reg_wdata = 32'h0;
		src       = 5'h0;
		osc       = 2'h0;
		sys_m     = 32'h0001_0000;
		osc_m     = 32'h0000_0030;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		rd(PCS_SYS_ADDR, sys_m);
		rd(PCS_OSC_ADDR, osc_m);
		chk_outs();
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			wr(PCS_SYS_ADDR, v);
			wr(PCS_OSC_ADDR, (v & 32'hffff_ff0e) | 32'h0000_0030);
			wr(32'h400f_4008, ~v);
			rd(PCS_SYS_ADDR, sys_m);
			rd(PCS_OSC_ADDR, osc_m);
			rd(32'h400f_4008, 32'h0);
			chk_outs();
		end
		for (int c = 0; c < 8; c++) begin
			wr(PCS_SYS_ADDR, 32'h0000_1000 | (c << 8) | ($random(seed) & 32'h7));
			pulses(1, 64);
			cmp(presc_cnt, c < 6 ? 64 >> c : 0);
		end
		for (int k = 0; k < 4; k++) begin
			wr(PCS_SYS_ADDR, CW[k]);
			pulses(CS[k], 16);
			cmp(tog_cnt, k == 1 ? 8 : 16);
		end
		for (int s = 0; s < 2; s++) begin
			wr(PCS_OSC_ADDR, 32'h0000_0030 | (s << 3));
			#1 cmp_bit(warmup_status, 1'b0);
			wr(PCS_OSC_ADDR, 32'h0000_0031 | (s << 3));
			#1 cmp_bit(warmup_status, 1'b1);
			rd(PCS_OSC_ADDR, osc_m | 32'h0000_0002);
			ticks(s, WT - 1);
			#1 cmp_bit(warmup_status, 1'b1);
			ticks(s, 1);
			#1 cmp_bit(warmup_status, 1'b0);
			rd(PCS_OSC_ADDR, osc_m);
		end
		final_report();
	end
endmodule : pcs_clock_ctrl_bench
`default_nettype wire
